// File: hw/sbs_top.sv
// supply backup sequencer: apb registers, core power sequence, monitors, wake logic
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/100ps
module sbs_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sleep_req,
   input wire logic sleep_on_handler_exit,
   input wire logic handler_exit,
   input wire logic [15:0] wake_input,
   input wire sbs_pkg::sbs_ana_s ana_in,
   output sbs_pkg::sbs_ctl_s ctl_out,
   output logic monitor_irq
);
   import sbs_pkg::*;

   sbs_state_e state_r;
   logic [31:0] smmr_r, mode_r, wumr_r, wuir_r;
   logic [31:0] backup_scratch_regs_r [SBS_NGPBR];
   logic [31:0] prdata_r;
   logic [2:0] cnt_r;
   logic bod_seen_r, bod_lost_r, bod_rst_r, brownout_reset_status_r;
   logic mon_rst_r, monitor_live_output_r, sms_r;
   logic [10:0] smp_cnt_r;
   logic [15:0] dbc_cnt_r;
   logic wake_block_r;
   logic [15:0] wk_latch_r;
   logic [1:0] lp_flag_r;
   logic [2:0] lp_cnt0_r, lp_cnt1_r;
   logic wave_d_r, backup_req_r, sleep_pend_r;
   logic core_nreset_r, core_stop_r, reg_en_r, mon_en_r, irq_r;

   // apb decode: zero-wait, always ready
   logic wr_en, rd_en, key_ok;
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   assign key_ok = pwdata[SBS_KEY_LSB +: 8] == SBS_KEY;

   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] b);
      return a == b;
   endfunction

   function automatic logic is_mapped(input logic [7:0] a);
      return (a <= SBS_ADDR_STAT && a[1:0] == 2'b00)
         || (a >= SBS_ADDR_BACKUP_SCRATCH_REGS && a < SBS_ADDR_BACKUP_SCRATCH_REGS + 8'(4 * SBS_NGPBR) && a[1:0] == 2'b00);
   endfunction

   logic cmd_regulator_off_cmd, mon_detect, mon_sample, wake_any, wake_dbc_done, lp_event, wake_start;
   logic [15:0] wk_qual;
   logic [15:0] dbc_target;
   logic [2:0] lp_need;
   logic wave_fall;

   // mode register guarded by key, the block needs other-party discipline
   assign cmd_regulator_off_cmd = wr_en & addr_hit(paddr, SBS_ADDR_CMD) & key_ok
      & pwdata[SBS_CMD_REGULATOR_OFF_CMD];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         smmr_r <= 32'h0000_0000;
         mode_r <= SBS_MODE_RESET;
         wumr_r <= 32'h0000_0000;
         wuir_r <= 32'h0000_0000;
      end else if (wr_en) begin
         if (addr_hit(paddr, SBS_ADDR_SMMR)) begin
            smmr_r <= {18'h0, pwdata[13:12], 1'b0, pwdata[10:8], 4'h0, pwdata[3:0]};
         end
         if (addr_hit(paddr, SBS_ADDR_MODE) && key_ok) begin
            mode_r <= {8'h00, 9'h0, pwdata[14:12], 12'h0};
         end
         if (addr_hit(paddr, SBS_ADDR_WUMR)) begin
            wumr_r <= {10'h0, pwdata[21:20], 1'b0, pwdata[18:16], 1'b0, pwdata[14:12],
               4'h0, pwdata[7:5], 1'b0, pwdata[3:1], 1'b0};
         end
         if (addr_hit(paddr, SBS_ADDR_WUIR)) begin
            wuir_r <= pwdata;
         end
      end
   end

   // backup scratch; low-power event clears the first half at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < SBS_NGPBR; i++) begin
            backup_scratch_regs_r[i] <= 32'h0000_0000;
         end
      end else begin
         for (int i = 0; i < SBS_NGPBR; i++) begin
            if (lp_event && wumr_r[SBS_WU_LPCLR] && i < SBS_NGPBR / 2) begin
               backup_scratch_regs_r[i] <= 32'h0000_0000;
            end else if (wr_en && paddr == SBS_ADDR_BACKUP_SCRATCH_REGS + 8'(4 * i)) begin
               backup_scratch_regs_r[i] <= pwdata;
            end
         end
      end
   end

   // read mux; a status read clears the sticky monitor bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata_r <= 32'h0000_0000;
         case (paddr)
            SBS_ADDR_SMMR: prdata_r <= smmr_r;
            SBS_ADDR_MODE: prdata_r <= mode_r;
            SBS_ADDR_WUMR: prdata_r <= wumr_r;
            SBS_ADDR_WUIR: prdata_r <= wuir_r;
            SBS_ADDR_STAT: prdata_r <= {wk_latch_r, 6'h0, lp_flag_r, 1'b0, monitor_live_output_r, sms_r,
               1'b0, brownout_reset_status_r, 3'h0};
            default: begin
               for (int i = 0; i < SBS_NGPBR; i++) begin
                  if (paddr == SBS_ADDR_BACKUP_SCRATCH_REGS + 8'(4 * i)) begin
                     prdata_r <= backup_scratch_regs_r[i];
                  end
               end
            end
         endcase
      end
   end
   assign prdata = prdata_r;
   assign pready = 1'b1;
   assign pslverr = 1'b0;

   // monitor sampling: continuous or one period in 32/256/2048
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         smp_cnt_r <= 11'h000;
      end else begin
         smp_cnt_r <= smp_cnt_r + 11'h001;
      end
   end
   always_comb begin
      case (smmr_r[SBS_SM_SMPL_LSB +: 3])
         SBS_SMPL_CONT: mon_sample = 1'b1;
         SBS_SMPL_32: mon_sample = smp_cnt_r[4:0] == 5'h00;
         SBS_SMPL_256: mon_sample = smp_cnt_r[7:0] == 8'h00;
         SBS_SMPL_2048: mon_sample = smp_cnt_r == 11'h000;
         default: mon_sample = 1'b0;
      endcase
   end
   // mon_en_r enables the comparator this period; ana_in.mon_low is sampled in the same period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mon_en_r <= 1'b0;
      end else begin
         mon_en_r <= mon_sample;
      end
   end
   assign mon_detect = mon_en_r & ana_in.mon_low;

   // live monitor output updates only on measurement cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         monitor_live_output_r <= 1'b0;
      end else if (mon_en_r) begin
         monitor_live_output_r <= ana_in.mon_low;
      end
   end

   // sticky detection; a set in the read cycle wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sms_r <= 1'b0;
      end else if (mon_detect) begin
         sms_r <= 1'b1;
      end else if (rd_en && addr_hit(paddr, SBS_ADDR_STAT)) begin
         sms_r <= 1'b0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= sms_r & smmr_r[SBS_SM_IEN];
      end
   end

   // monitor reset: held at least one cycle per detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mon_rst_r <= 1'b0;
      end else begin
         mon_rst_r <= mon_detect & smmr_r[SBS_SM_RSTEN];
      end
   end

   // brownout: loss on two consecutive cycles with regulator on starts reset until good returns
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bod_lost_r <= 1'b0;
         bod_rst_r <= 1'b0;
         brownout_reset_status_r <= 1'b0;
      end else begin
         bod_lost_r <= ~ana_in.bod_good & reg_en_r;
         if (bod_lost_r && !ana_in.bod_good && reg_en_r && mode_r[SBS_MR_BROWNOUT_RESET_ENABLE]
               && state_r == SBS_RUN) begin
            bod_rst_r <= 1'b1;
            brownout_reset_status_r <= 1'b1;
         end else if (ana_in.bod_good) begin
            bod_rst_r <= 1'b0;
         end
      end
   end

   // sixteen wake inputs: enable and polarity, ORed into one counter
   assign wk_qual = wuir_r[15:0] & ~(wake_input ^ wuir_r[31:16]);
   assign wake_any = |wk_qual;
   always_comb begin
      case (wumr_r[SBS_WU_DBC_LSB +: 3])
         3'h1: dbc_target = SBS_DBC_3;
         3'h2: dbc_target = SBS_DBC_32;
         3'h3: dbc_target = SBS_DBC_512;
         3'h4: dbc_target = SBS_DBC_4096;
         3'h5: dbc_target = SBS_DBC_32768;
         default: dbc_target = 16'h0000;
      endcase
   end
   assign wake_dbc_done = wake_any & (dbc_target == 16'h0000 || dbc_cnt_r == dbc_target);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dbc_cnt_r <= 16'h0000;
         wake_block_r <= 1'b0;
         wk_latch_r <= 16'h0000;
      end else begin
         dbc_cnt_r <= (wake_any && !wake_dbc_done) ? dbc_cnt_r + 16'h0001 : 16'h0000;
         if (!wake_any) begin
            wake_block_r <= 1'b0;
         end else if (wake_dbc_done && !wake_block_r) begin
            wake_block_r <= 1'b1;
            wk_latch_r <= wake_input;
         end
      end
   end

   // low-power debouncers sample on falling edges of the rtc wave
   assign wave_fall = wave_d_r & ~ana_in.rtc_wave;
   assign lp_need = wumr_r[SBS_WU_LOWPOWER_DEBOUNCE_COUNT_LSB +: 3] + 3'h1;
   logic lp_hit0, lp_hit1;
   assign lp_hit0 = wumr_r[SBS_WU_LPEN0] & (wake_input[0] == wumr_r[SBS_WU_LPPOL_LSB]);
   assign lp_hit1 = wumr_r[SBS_WU_LPEN0 + 1] & (wake_input[1] == wumr_r[SBS_WU_LPPOL_LSB + 1]);
   logic lp_done0, lp_done1;
   assign lp_done0 = wave_fall & lp_hit0 & (lp_cnt0_r + 3'h1 == lp_need);
   assign lp_done1 = wave_fall & lp_hit1 & (lp_cnt1_r + 3'h1 == lp_need);
   assign lp_event = (lp_done0 | lp_done1) & (wumr_r[SBS_WU_LOWPOWER_DEBOUNCE_COUNT_LSB +: 3] != 3'h0);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wave_d_r <= 1'b0;
         lp_cnt0_r <= 3'h0;
         lp_cnt1_r <= 3'h0;
         lp_flag_r <= 2'b00;
      end else begin
         wave_d_r <= ana_in.rtc_wave;
         if (wave_fall) begin
            lp_cnt0_r <= (lp_hit0 && !lp_done0) ? lp_cnt0_r + 3'h1 : 3'h0;
            lp_cnt1_r <= (lp_hit1 && !lp_done1) ? lp_cnt1_r + 3'h1 : 3'h0;
         end
         if (lp_event) begin
            lp_flag_r <= lp_flag_r | {lp_done1, lp_done0};
         end else if (rd_en && addr_hit(paddr, SBS_ADDR_STAT)) begin
            lp_flag_r <= 2'b00;
         end
      end
   end

   // any enabled wake source restarts the core
   assign wake_start = (wake_dbc_done & ~wake_block_r) | lp_event
      | (mon_detect & wumr_r[SBS_WU_MONITOR_WAKE_ENABLE])
      | (ana_in.rtc_alarm & wumr_r[SBS_WU_RTC_ALARM_WAKE_ENABLE]) | (ana_in.rtt_alarm & wumr_r[SBS_WU_RTT_ALARM_WAKE_ENABLE]);

   // sleep-on-exit request waits here, the handler may run for many cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_pend_r <= 1'b0;
      end else if (handler_exit) begin
         sleep_pend_r <= 1'b0;
      end else if (sleep_req && sleep_on_handler_exit) begin
         sleep_pend_r <= 1'b1;
      end
   end

   // backup request: command or sleep instruction, resynchronised one stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         backup_req_r <= 1'b0;
      end else begin
         backup_req_r <= cmd_regulator_off_cmd
            | (sleep_req & ~sleep_on_handler_exit)
            | ((sleep_pend_r | (sleep_req & sleep_on_handler_exit)) & handler_exit);
      end
   end

   // core power sequence
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= SBS_SETTLE;
         cnt_r <= 3'h0;
         bod_seen_r <= 1'b0;
         core_nreset_r <= 1'b0;
         core_stop_r <= 1'b1;
         reg_en_r <= 1'b0;
      end else begin
         case (state_r)
            SBS_SETTLE: begin
               cnt_r <= cnt_r + 3'h1;
               if (cnt_r + 3'h1 == SBS_POR_CYCLES) begin
                  state_r <= SBS_REGON;
                  reg_en_r <= mode_r[SBS_MR_REGULATOR_IN_USE];
               end
            end
            SBS_REGON: begin
               bod_seen_r <= ana_in.bod_good;
               if (bod_seen_r && ana_in.bod_good) begin
                  state_r <= SBS_RUN;
                  core_nreset_r <= 1'b1;
                  core_stop_r <= 1'b0;
               end
            end
            SBS_RUN: begin
               reg_en_r <= mode_r[SBS_MR_REGULATOR_IN_USE];
               core_nreset_r <= ~(mon_rst_r | bod_rst_r
                  | (mon_detect & smmr_r[SBS_SM_RSTEN]));
               if (backup_req_r) begin
                  state_r <= SBS_STOP;
                  core_nreset_r <= 1'b0;
                  core_stop_r <= 1'b1;
               end
            end
            SBS_STOP: begin
               state_r <= SBS_OFF;
               reg_en_r <= 1'b0;
               bod_seen_r <= 1'b0;
            end
            SBS_OFF: begin
               cnt_r <= 3'h0;
               if (wake_start) begin
                  state_r <= SBS_SETTLE;
               end
            end
            default: state_r <= SBS_OFF;
         endcase
      end
   end

   assign ctl_out = '{core_nreset: core_nreset_r, core_stop: core_stop_r, reg_enable: reg_en_r,
      mon_enable: mon_en_r, mon_threshold: smmr_r[SBS_SM_TH_LSB +: 4]};
   assign monitor_irq = irq_r;

   // checks
   chk_backup_reset: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_regulator_off_cmd && state_r == SBS_RUN |-> ##[1:2] !core_nreset_r)
      else $error("core reset late after backup request");
   chk_stop_before_off: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == SBS_STOP |-> core_stop_r && reg_en_r ##1 !reg_en_r)
      else $error("regulator off without stop cycle");
   chk_settle_count: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(state_r == SBS_REGON) |-> $past(state_r == SBS_SETTLE, 5))
      else $error("settle shorter than five cycles");
   chk_bod_release: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(core_nreset_r) && $past(state_r) == SBS_REGON |-> $past(ana_in.bod_good, 2))
      else $error("core reset released before brownout good");
   chk_bod_reset: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(bod_rst_r) |-> brownout_reset_status_r ##1 !core_nreset_r)
      else $error("brownout reset not applied");
   chk_mon_reset: assert property (@(posedge pclk) disable iff (!presetn)
      mon_detect && smmr_r[SBS_SM_RSTEN] && state_r == SBS_RUN && !backup_req_r
      |=> !core_nreset_r)
      else $error("monitor reset missing");
   chk_sticky_set: assert property (@(posedge pclk) disable iff (!presetn)
      mon_detect |=> sms_r)
      else $error("sticky monitor bit not set");
   chk_lp_clear: assert property (@(posedge pclk) disable iff (!presetn)
      lp_event && wumr_r[SBS_WU_LPCLR] |=> backup_scratch_regs_r[0] == 32'h0000_0000)
      else $error("backup scratch not cleared");
   chk_wake_latch: assert property (@(posedge pclk) disable iff (!presetn)
      wake_block_r && wake_any |=> $stable(wk_latch_r))
      else $error("wake latch overwritten while blocked");
   cov_backup: cover property (@(posedge pclk) state_r == SBS_STOP);
   cov_wake: cover property (@(posedge pclk) state_r == SBS_OFF && wake_start);
   cov_bod: cover property (@(posedge pclk) $rose(bod_rst_r));
   cov_lp: cover property (@(posedge pclk) lp_event);
endmodule

// File: common/sbs_pkg.sv
// package of constants and types for the supply backup sequencer
package sbs_pkg;
   localparam logic [7:0] SBS_ADDR_CMD = 8'h00;
   localparam logic [7:0] SBS_ADDR_SMMR = 8'h04;
   localparam logic [7:0] SBS_ADDR_MODE = 8'h08;
   localparam logic [7:0] SBS_ADDR_WUMR = 8'h0C;
   localparam logic [7:0] SBS_ADDR_WUIR = 8'h10;
   localparam logic [7:0] SBS_ADDR_STAT = 8'h14;
   localparam logic [7:0] SBS_ADDR_BACKUP_SCRATCH_REGS = 8'h20;
   localparam logic [7:0] SBS_KEY = 8'hA5;
   localparam int SBS_KEY_LSB = 24;
   localparam logic [31:0] SBS_MODE_RESET = 32'h0000_5A00;
   localparam int SBS_CMD_REGULATOR_OFF_CMD = 2;
   localparam int SBS_SM_TH_LSB = 0;
   localparam int SBS_SM_SMPL_LSB = 8;
   localparam int SBS_SM_RSTEN = 12;
   localparam int SBS_SM_IEN = 13;
   localparam int SBS_MR_BROWNOUT_RESET_ENABLE = 12;
   localparam int SBS_MR_REGULATOR_IN_USE = 14;
   localparam int SBS_WU_MONITOR_WAKE_ENABLE = 1;
   localparam int SBS_WU_RTT_ALARM_WAKE_ENABLE = 2;
   localparam int SBS_WU_RTC_ALARM_WAKE_ENABLE = 3;
   localparam int SBS_WU_LPEN0 = 5;
   localparam int SBS_WU_LPCLR = 7;
   localparam int SBS_WU_DBC_LSB = 12;
   localparam int SBS_WU_LOWPOWER_DEBOUNCE_COUNT_LSB = 16;
   localparam int SBS_WU_LPPOL_LSB = 20;
   localparam int SBS_ST_BROWNOUT_RESET_STATUS = 3;
   localparam int SBS_ST_SMS = 5;
   localparam int SBS_ST_MONITOR_LIVE_OUTPUT = 6;
   localparam int SBS_ST_LP_LSB = 8;
   localparam int SBS_ST_WK_LSB = 16;
   localparam logic [2:0] SBS_SMPL_OFF = 3'h0;
   localparam logic [2:0] SBS_SMPL_CONT = 3'h1;
   localparam logic [2:0] SBS_SMPL_32 = 3'h2;
   localparam logic [2:0] SBS_SMPL_256 = 3'h3;
   localparam logic [2:0] SBS_SMPL_2048 = 3'h4;
   localparam logic [15:0] SBS_DBC_3 = 16'h0002;
   localparam logic [15:0] SBS_DBC_32 = 16'h001F;
   localparam logic [15:0] SBS_DBC_512 = 16'h01FF;
   localparam logic [15:0] SBS_DBC_4096 = 16'h0FFF;
   localparam logic [15:0] SBS_DBC_32768 = 16'h7FFF;
   localparam logic [2:0] SBS_POR_CYCLES = 3'h5;
   localparam int SBS_NGPBR = 8;
   localparam int SBS_NWAKE = 16;

   // core sequencer states, gray along off -> settle -> reg -> run -> stop
   typedef enum logic [2:0] {
      SBS_OFF = 3'b000,
      SBS_SETTLE = 3'b001,
      SBS_REGON = 3'b011,
      SBS_RUN = 3'b010,
      SBS_STOP = 3'b110,
      SBS_RESYNC = 3'b111
   } sbs_state_e;

   // analogue and alarm inputs grouped
   typedef struct packed {
      logic bod_good;
      logic mon_low;
      logic rtc_alarm;
      logic rtt_alarm;
      logic rtc_wave;
   } sbs_ana_s;

   // core control outputs grouped
   typedef struct packed {
      logic core_nreset;
      logic core_stop;
      logic reg_enable;
      logic mon_enable;
      logic [3:0] mon_threshold;
   } sbs_ctl_s;
endpackage

// File: testbench/sbs_ana_model.sv
// analogue far side: core supply ramp, brownout detector, monitor, alarms, rtc wave
`timescale 1ns/100ps
module sbs_ana_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire sbs_pkg::sbs_ctl_s ctl,
   input wire logic bod_fault,
   input wire logic vio_low,
   input wire logic [1:0] alarm,
   output sbs_pkg::sbs_ana_s ana
);
   import sbs_pkg::*;
   logic [1:0] ramp_r;
   logic [2:0] wave_r;
   // core supply needs two cycles to come up after the regulator is enabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ramp_r <= 2'h0;
      end else begin
         ramp_r <= {ramp_r[0], ctl.reg_enable};
      end
   end
   // free square wave for the low-power samplers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wave_r <= 3'h0;
      end else begin
         wave_r <= wave_r + 3'h1;
      end
   end
   // detector output only means something while the core supply is up
   assign ana.bod_good = ramp_r[1] & ~bod_fault;
   assign ana.mon_low = vio_low & ctl.mon_enable; // unpowered monitor reports nothing
   assign ana.rtc_alarm = alarm[1];
   assign ana.rtt_alarm = alarm[0];
   assign ana.rtc_wave = wave_r[2]; // square wave
endmodule

// File: testbench/sbs_top_tb.sv
// self-checking bench for the supply backup sequencer
`timescale 1ns/100ps
module sbs_top_tb;
   import sbs_pkg::*;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, monitor_irq, bod_fault = 1'h0, vio_low = 1'h0;
   logic sleep_req = 1'h0, sleep_on_handler_exit = 1'h0, handler_exit = 1'h0;
   logic [1:0] alarm = 2'h0;
   logic [15:0] wake_input = 16'h0000;
   sbs_ana_s ana;
   sbs_ctl_s ctl;
   int mismatches = 0, samples_checked = 0, n;
   always #50 pclk = ~pclk;
   sbs_top i_sbs_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sleep_req(sleep_req), .sleep_on_handler_exit(sleep_on_handler_exit),
      .handler_exit(handler_exit), .wake_input(wake_input), .ana_in(ana), .ctl_out(ctl),
      .monitor_irq(monitor_irq));
   sbs_ana_model i_sbs_ana_model (.pclk(pclk), .presetn(presetn), .ctl(ctl),
      .bod_fault(bod_fault), .vio_low(vio_low), .alarm(alarm), .ana(ana));
   task tick;
      @(posedge pclk);
      #1;
   endtask
   task chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   task chk_count(input string name, input int lo, input int hi, input int got);
      samples_checked++;
      if (got < lo || got > hi) begin
         mismatches++;
         $display("BAD %s expected %0d..%0d seen %0d", name, lo, hi, got);
      end
   endtask
   // one apb transfer; request held until pready is seen high at an edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      rd = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
      #1;
   endtask
   function automatic logic sel(input int k);
      case (k)
         0: sel = ctl.core_nreset;
         1: sel = ctl.reg_enable;
         default: sel = monitor_irq;
      endcase
   endfunction
   // bounded poll; a timeout leaves n at the limit so range checks fail
   task wait_ctl(input int k, input logic v, input int lim);
      n = 0;
      while (sel(k) !== v && n < lim) begin
         tick;
         n++;
      end
   endtask
   // backup through a sleep instruction, woken again by one alarm
   task sleep_cycle(input logic on_exit, input logic [1:0] al);
      @(posedge pclk);
      sleep_on_handler_exit <= on_exit;
      sleep_req <= 1'h1;
      @(posedge pclk);
      sleep_req <= 1'h0;
      if (on_exit) begin
         repeat (5) tick;
         chk_word("exit_wait", 32'h1, {31'h0, ctl.core_nreset});
         @(posedge pclk);
         handler_exit <= 1'h1;
         @(posedge pclk);
         handler_exit <= 1'h0;
      end
      #1;
      wait_ctl(0, 1'h0, 3);
      chk_count("sleep_rst", 0, 2, n);
      wait_ctl(1, 1'h0, 6);
      @(posedge pclk);
      alarm <= al;
      #1;
      wait_ctl(1, 1'h1, 20);
      chk_count("alarm_wake", 5, 19, n);
      @(posedge pclk);
      alarm <= 2'h0;
      #1;
      wait_ctl(0, 1'h1, 20);
      chk_count("alarm_up", 0, 19, n);
      $display("test sleep %0d done", on_exit);
   endtask
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (4000) @(posedge pclk);
      mismatches++;
      tally_and_finish;
   end
   initial begin
      repeat (3) tick;
      chk_word("rst_ctl", 32'h2, {29'h0, ctl.core_nreset, ctl.core_stop, ctl.reg_enable});
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      #1;
      wait_ctl(1, 1'h1, 20);
      chk_count("settle", 5, 7, n);
      wait_ctl(0, 1'h1, 20);
      chk_count("bod_hold", 3, 9, n);
      apb(1'h0, SBS_ADDR_MODE, 32'h0);
      chk_word("mode_rst", SBS_MODE_RESET, rd & 32'h00FF_FFFF);
      apb(1'h1, SBS_ADDR_MODE, 32'h5A00_1000);
      apb(1'h0, SBS_ADDR_MODE, 32'h0);
      chk_word("mode_key", SBS_MODE_RESET, rd & 32'h00FF_FFFF);
      chk_word("reg_kept", 32'h1, {31'h0, ctl.reg_enable});
      $display("test power_up done");
      apb(1'h1, SBS_ADDR_SMMR, 32'h0000_0200);
      n = 0;
      repeat (64) begin
         tick;
         n += ctl.mon_enable;
      end
      chk_count("smpl32", 2, 2, n);
      apb(1'h1, SBS_ADDR_SMMR, 32'h0000_3109);
      chk_word("mon_th", 32'h9, {28'h0, ctl.mon_threshold});
      apb(1'h0, SBS_ADDR_SMMR, 32'h0);
      chk_word("smmr", 32'h0000_3109, rd);
      @(posedge pclk);
      vio_low <= 1'h1;
      #1;
      wait_ctl(0, 1'h0, 5);
      chk_count("mon_rst", 0, 4, n);
      wait_ctl(2, 1'h1, 5);
      chk_count("mon_irq", 0, 4, n);
      @(posedge pclk);
      vio_low <= 1'h0;
      #1;
      wait_ctl(0, 1'h1, 40);
      chk_count("mon_back", 0, 39, n);
      apb(1'h0, SBS_ADDR_STAT, 32'h0);
      chk_word("sms_set", 32'h20, rd & 32'h60);
      apb(1'h0, SBS_ADDR_STAT, 32'h0);
      chk_word("sms_clr", 32'h0, (rd & 32'h20) | {31'h0, monitor_irq});
      apb(1'h1, SBS_ADDR_SMMR, 32'h0);
      $display("test monitor done");
      @(posedge pclk);
      bod_fault <= 1'h1;
      #1;
      wait_ctl(0, 1'h0, 6);
      chk_count("bod_rst", 2, 5, n);
      repeat (3) tick;
      chk_word("bod_hold_rst", 32'h0, {31'h0, ctl.core_nreset});
      @(posedge pclk);
      bod_fault <= 1'h0;
      #1;
      wait_ctl(0, 1'h1, 20);
      chk_count("bod_end", 1, 19, n);
      apb(1'h0, SBS_ADDR_STAT, 32'h0);
      chk_word("bod_stat", 32'h8, rd & 32'h8);
      $display("test brownout done");
      apb(1'h1, SBS_ADDR_BACKUP_SCRATCH_REGS, 32'h1234_5678);
      apb(1'h1, SBS_ADDR_BACKUP_SCRATCH_REGS + 8'h10, 32'h1234_ABCD);
      apb(1'h1, SBS_ADDR_WUMR, 32'h0011_00A0);
      @(posedge pclk);
      wake_input <= 16'h0001;
      repeat (24) tick;
      @(posedge pclk);
      wake_input <= 16'h0000;
      apb(1'h0, SBS_ADDR_BACKUP_SCRATCH_REGS, 32'h0);
      chk_word("backup_scratch_regs_clr", 32'h0, rd);
      apb(1'h0, SBS_ADDR_BACKUP_SCRATCH_REGS + 8'h10, 32'h0);
      chk_word("backup_scratch_regs_kept", 32'h1234_ABCD, rd);
      apb(1'h0, SBS_ADDR_STAT, 32'h0);
      chk_word("lp_flag", 32'h100, rd & 32'h300);
      $display("test lowpower done");
      apb(1'h1, SBS_ADDR_CMD, 32'h5A00_0004);
      repeat (6) tick;
      chk_word("cmd_key", 32'h1, {31'h0, ctl.core_nreset});
      apb(1'h1, SBS_ADDR_WUIR, 32'h0008_0008);
      apb(1'h1, SBS_ADDR_WUMR, 32'h0000_100C);
      apb(1'h1, SBS_ADDR_CMD, 32'hA500_0004);
      wait_ctl(0, 1'h0, 3);
      chk_count("bk_rst", 0, 2, n);
      wait_ctl(1, 1'h0, 4);
      chk_count("bk_off", 1, 3, n);
      chk_word("bk_stop", 32'h1, {31'h0, ctl.core_stop});
      @(posedge pclk);
      wake_input <= 16'h0008;
      repeat (2) @(posedge pclk);
      wake_input <= 16'h0000;
      repeat (8) tick;
      chk_word("wk_short", 32'h0, {31'h0, ctl.reg_enable});
      @(posedge pclk);
      wake_input <= 16'h0008;
      #1;
      wait_ctl(1, 1'h1, 30);
      chk_count("wk_dbc", 8, 20, n);
      wait_ctl(0, 1'h1, 20);
      chk_count("wk_up", 0, 19, n);
      apb(1'h0, SBS_ADDR_STAT, 32'h0);
      chk_word("wk_latch", 32'h0008_0000, rd & 32'hFFFF_0000);
      @(posedge pclk);
      wake_input <= 16'h0000;
      $display("test backup done");
      sleep_cycle(1'h0, 2'h2);
      sleep_cycle(1'h1, 2'h1);
      tally_and_finish;
   end
endmodule
